/* File: src/mecs_pkg.sv */
// Constants, field layouts and carrier types of the motion event register bank.
package mecs_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_TAP_TIMING = 6'h32;
    localparam logic [5:0] IDX_WAKE_THS = 6'h33;
    localparam logic [5:0] IDX_WAKE_DUR = 6'h34;
    localparam logic [5:0] IDX_FREEFALL = 6'h35;
    localparam logic [5:0] IDX_STATUS = 6'h36;
    localparam logic [5:0] IDX_WAKE_SRC = 6'h37;

    // Reset value of every configuration register.
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Duration scale factors in output data periods.
    localparam int SHOCK_MULT = 8;
    localparam int QUIET_MULT = 4;
    localparam int GAP_MULT = 32;
    localparam int SLEEP_MULT = 512;

    // Counter widths.
    localparam int TCNT_W = 9;
    localparam int ICNT_W = 13;

    // Tap timing register fields.
    localparam int GAP_LSB = 4;
    localparam int QUIET_LSB = 2;
    localparam int SHOCK_LSB = 0;
    // Wake threshold register fields.
    localparam int DBL_BIT = 7;
    localparam int SLEEP_EN_BIT = 6;
    localparam int WTHS_LSB = 0;
    // Wake and sleep duration register fields.
    localparam int FDUR5_BIT = 7;
    localparam int WDUR_LSB = 5;
    localparam int ROUTE_BIT = 4;
    localparam int SDLY_LSB = 0;
    // Free-fall register fields.
    localparam int FDUR_LSB = 3;
    localparam int FTHS_LSB = 0;

    // Event flags laid out as the status mirror register, bit 7 first.
    typedef struct packed {
        logic overrun;
        logic wake;
        logic sleep;
        logic dtap;
        logic stap;
        logic orient;
        logic fall;
        logic ready;
    } mecs_evt_t;

    // Per-axis magnitudes in steps of one sixty-fourth of full scale.
    typedef struct packed {
        logic [5:0] x;
        logic [5:0] y;
        logic [5:0] z;
    } mecs_axis_t;

    // Free-fall threshold decode, in steps of 31.25 mg.
    function automatic logic [4:0] mecs_fall_ths(input logic [2:0] code);
        logic [4:0] r;
        r = 5'h05;
        case (code)
            3'h0: r = 5'h05;
            3'h1: r = 5'h07;
            3'h2: r = 5'h08;
            3'h3: r = 5'h0a;
            3'h4: r = 5'h0b;
            3'h5: r = 5'h0d;
            3'h6: r = 5'h0f;
            default: r = 5'h10;
        endcase
        return r;
    endfunction : mecs_fall_ths

endpackage : mecs_pkg

/* File: src/mecs_regs.sv */
// Motion event configuration and status bank with tap, wake, sleep and fall.
`timescale 1ns/1ps

// What this block does
// - In double mode a second tap counts only within gap field times 32 periods.
// - After a first tap no over-threshold sample for quiet field times 4.
// - An excursion is a tap only if no longer than shock field times 8.
// - Tap count select 0 gives single-tap detection, 1 gives double-tap.
// - Inactivity enable bit switches sleep detection off at 0, on at 1.
// - Wake threshold is 6-bit unsigned, one step is full scale over 64.
// - Fall duration is 6 bits split over two registers, one period a step.
// - Wake duration is a 2-bit field, one period a step.
// - Route bit 1 drives the FIFO full status onto interrupt pin one.
// - Sleep is entered after inactivity of sleep delay times 512 periods.
// - Fall threshold code decodes to 5,7,8,10,11,13,15,16 steps of 31.25 mg.
// - Status mirror bits are overrun down to sample ready; overrun on overwrite while the FIFO is full.
// - Sample ready reads 1 when new X, Y and Z data are available.
// - Orientation flag sets when a change of position is detected.
// - Wake source bits 2 to 0 flag the axis that caused a wakeup.
// - Wake source bit 3 wake, bit 4 inactive, bit 5 fall, bits 7:6 zero.
// - Inactive state flag reads 1 while a sleep event is detected.
// - Double knock flag sets on a double tap, single on a single tap.
// - Fall flag sets after fall duration below the fall threshold.
module mecs_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic odr_tick_i,
    input wire logic data_ready_i,
    input wire logic tap_over_i,
    input wire mecs_pkg::mecs_axis_t axis_mag_i,
    input wire logic [7:0] fall_mag_i,
    input wire logic orient_change_i,
    input wire logic fifo_full_i,
    input wire logic fifo_overwrite_i,
    output mecs_pkg::mecs_evt_t evt_o,
    output logic interrupt_pin_one_o
);
    import mecs_pkg::*;

    typedef enum logic [2:0] {
        T_IDLE, T_SHOCK, T_HOLD, T_QUIET, T_GAP
    } mecs_tap_st_t;

    logic [7:0] tap_cfg_q;
    logic [7:0] wths_cfg_q;
    logic [7:0] wdur_cfg_q;
    logic [7:0] fall_cfg_q;
    logic [31:0] dat_q;
    logic ack_q;
    mecs_evt_t evt_q;
    logic [2:0] axis_q;
    logic int_q;
    mecs_tap_st_t st_q;
    logic [TCNT_W-1:0] tcnt_q;
    logic second_q;
    logic stap_p_q;
    logic dtap_p_q;
    logic [1:0] wcnt_q;
    logic [ICNT_W-1:0] icnt_q;
    logic [5:0] fcnt_q;

    logic req;
    logic hit;
    logic [5:0] idx;
    logic wr;
    logic rd_status;
    logic rd_src;
    logic [2:0] over;
    logic any_over;
    logic wake_p;
    logic fall_low;
    logic fall_p;
    logic sleep_en;
    logic dbl;
    logic [5:0] fall_dur;
    logic [TCNT_W-1:0] shock_lim;
    logic [TCNT_W-1:0] quiet_lim;
    logic [TCNT_W-1:0] gap_lim;
    logic [ICNT_W-1:0] sleep_lim;

    // Bus request decode: aligned word per register, low byte lane holds data.
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign idx = wb_adr_i[7:2];
    assign hit = wb_adr_i[1:0] == 2'h0;
    assign wr = req && wb_we_i && hit && wb_sel_i[0];
    assign rd_status = req && !wb_we_i && hit && idx == IDX_STATUS;
    assign rd_src = req && !wb_we_i && hit && idx == IDX_WAKE_SRC;

    // Configuration fields.
    assign dbl = wths_cfg_q[DBL_BIT];
    assign sleep_en = wths_cfg_q[SLEEP_EN_BIT];
    assign fall_dur = {wdur_cfg_q[FDUR5_BIT], fall_cfg_q[FDUR_LSB +: 5]};
    assign shock_lim = TCNT_W'(tap_cfg_q[SHOCK_LSB +: 2] * SHOCK_MULT);
    assign quiet_lim = TCNT_W'(tap_cfg_q[QUIET_LSB +: 2] * QUIET_MULT);
    assign gap_lim = TCNT_W'(tap_cfg_q[GAP_LSB +: 4] * GAP_MULT);
    assign sleep_lim = ICNT_W'(wdur_cfg_q[SDLY_LSB +: 4] * SLEEP_MULT);

    // Per-axis wake comparison against the unsigned threshold.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            logic [5:0] mag;
            assign mag = axis_mag_i[6*g +: 6];
            assign over[g] = mag > wths_cfg_q[WTHS_LSB +: 6];
        end
    endgenerate
    assign any_over = |over;
    assign wake_p = odr_tick_i && any_over
        && wcnt_q == wdur_cfg_q[WDUR_LSB +: 2];
    assign fall_low = fall_mag_i
        < 8'(mecs_fall_ths(fall_cfg_q[FTHS_LSB +: 3]));
    assign fall_p = odr_tick_i && fall_low && fcnt_q == fall_dur;

    // Configuration registers; writes to status and source are dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tap_cfg_q <= CFG_RESET;
            wths_cfg_q <= CFG_RESET;
            wdur_cfg_q <= CFG_RESET;
            fall_cfg_q <= CFG_RESET;
        end else if (wr) begin
            unique case (idx)
                IDX_TAP_TIMING: tap_cfg_q <= wb_dat_i[7:0];
                IDX_WAKE_THS: wths_cfg_q <= wb_dat_i[7:0];
                IDX_WAKE_DUR: wdur_cfg_q <= wb_dat_i[7:0];
                IDX_FREEFALL: fall_cfg_q <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Bus answer: one wait state, read data registered with the ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= req;
            dat_q <= 32'h0;
            if (req && !wb_we_i && hit) begin
                unique case (idx)
                    IDX_TAP_TIMING: dat_q[7:0] <= tap_cfg_q;
                    IDX_WAKE_THS: dat_q[7:0] <= wths_cfg_q;
                    IDX_WAKE_DUR: dat_q[7:0] <= wdur_cfg_q;
                    IDX_FREEFALL: dat_q[7:0] <= fall_cfg_q;
                    IDX_STATUS: dat_q[7:0] <= evt_q;
                    IDX_WAKE_SRC: dat_q[7:0] <= {2'h0, evt_q.fall,
                        evt_q.sleep, evt_q.wake, axis_q};
                    default: dat_q <= 32'h0;
                endcase
            end
        end
    end

    // Tap recognition; every timer steps on the data period tick.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= T_IDLE;
            tcnt_q <= '0;
            second_q <= 1'b0;
            stap_p_q <= 1'b0;
            dtap_p_q <= 1'b0;
        end else begin
            stap_p_q <= 1'b0;
            dtap_p_q <= 1'b0;
            unique case (st_q)
                T_IDLE: begin
                    second_q <= 1'b0;
                    tcnt_q <= TCNT_W'(1);
                    if (odr_tick_i && tap_over_i) begin
                        st_q <= T_SHOCK;
                    end
                end
                T_SHOCK: if (odr_tick_i) begin
                    if (tap_over_i) begin
                        if (tcnt_q >= shock_lim) begin
                            st_q <= T_HOLD;
                        end else begin
                            tcnt_q <= tcnt_q + 1'b1;
                        end
                    end else if (tcnt_q <= shock_lim) begin
                        tcnt_q <= '0;
                        st_q <= T_QUIET;
                        if (!dbl) begin
                            stap_p_q <= 1'b1;
                        end else if (second_q) begin
                            dtap_p_q <= 1'b1;
                        end
                    end else begin
                        st_q <= T_IDLE;
                    end
                end
                T_HOLD: if (!tap_over_i) begin
                    st_q <= T_IDLE;
                end
                T_QUIET: if (odr_tick_i) begin
                    if (tap_over_i) begin
                        st_q <= T_HOLD;
                    end else begin
                        tcnt_q <= tcnt_q + 1'b1;
                        if (tcnt_q + 1'b1 >= quiet_lim) begin
                            st_q <= (dbl && !second_q) ? T_GAP : T_IDLE;
                        end
                    end
                end
                T_GAP: if (odr_tick_i) begin
                    if (tcnt_q >= gap_lim) begin
                        st_q <= T_IDLE;
                    end else if (tap_over_i) begin
                        second_q <= 1'b1;
                        tcnt_q <= TCNT_W'(1);
                        st_q <= T_SHOCK;
                    end else begin
                        tcnt_q <= tcnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // Wake and free-fall duration counters of consecutive samples.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wcnt_q <= 2'h0;
            fcnt_q <= 6'h0;
        end else if (odr_tick_i) begin
            if (!any_over) begin
                wcnt_q <= 2'h0;
            end else if (wcnt_q != wdur_cfg_q[WDUR_LSB +: 2]) begin
                wcnt_q <= wcnt_q + 1'b1;
            end
            if (!fall_low) begin
                fcnt_q <= 6'h0;
            end else if (fcnt_q != fall_dur) begin
                fcnt_q <= fcnt_q + 1'b1;
            end
        end
    end

    // Inactivity counter; it restarts on any over-threshold sample.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            icnt_q <= '0;
        end else if (!sleep_en || any_over) begin
            icnt_q <= '0;
        end else if (odr_tick_i && icnt_q < sleep_lim) begin
            icnt_q <= icnt_q + 1'b1;
        end
    end

    // Event flags: a set in the clearing read cycle wins over the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_q <= '0;
            axis_q <= 3'h0;
        end else begin
            if (rd_status) begin
                evt_q.ready <= 1'b0;
                evt_q.stap <= 1'b0;
                evt_q.dtap <= 1'b0;
                evt_q.orient <= 1'b0;
                evt_q.overrun <= 1'b0;
            end
            if (rd_status || rd_src) begin
                evt_q.wake <= 1'b0;
                evt_q.fall <= 1'b0;
            end
            if (rd_src) begin
                axis_q <= 3'h0;
            end
            if (data_ready_i) begin
                evt_q.ready <= 1'b1;
            end
            if (orient_change_i) begin
                evt_q.orient <= 1'b1;
            end
            if (fifo_full_i && fifo_overwrite_i) begin
                evt_q.overrun <= 1'b1;
            end
            if (stap_p_q) begin
                evt_q.stap <= 1'b1;
            end
            if (dtap_p_q) begin
                evt_q.dtap <= 1'b1;
            end
            if (fall_p) begin
                evt_q.fall <= 1'b1;
            end
            if (wake_p) begin
                evt_q.wake <= 1'b1;
                axis_q <= (rd_src ? 3'h0 : axis_q) | over;
            end
            if (!sleep_en || wake_p) begin
                evt_q.sleep <= 1'b0;
            end else if (icnt_q >= sleep_lim) begin
                evt_q.sleep <= 1'b1;
            end
        end
    end

    // FIFO full routing onto interrupt pin one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_q <= 1'b0;
        end else begin
            int_q <= fifo_full_i && wdur_cfg_q[ROUTE_BIT];
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign evt_o = evt_q;
    assign interrupt_pin_one_o = int_q;

    sequence s_req;
        wb_cyc_i && wb_stb_i && !ack_q;
    endsequence
    sequence s_src_read;
        s_req ##0 (!wb_we_i && hit && idx == IDX_WAKE_SRC);
    endsequence

    property p_ack;
        @(posedge clk_i) disable iff (rst_i) s_req |=> ack_q ##1 !ack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");

    property p_route;
        @(posedge clk_i) disable iff (rst_i)
        ##1 int_q == $past(fifo_full_i && wdur_cfg_q[ROUTE_BIT]);
    endproperty
    a_route: assert property (p_route) else $error("pin one mismatch");

    property p_src_top;
        @(posedge clk_i) disable iff (rst_i) s_src_read |=> dat_q[7:6] == 2'h0;
    endproperty
    a_src_top: assert property (p_src_top) else $error("src top set");

    property p_shock;
        @(posedge clk_i) disable iff (rst_i)
        st_q == T_SHOCK |-> tcnt_q <= shock_lim + 1'b1;
    endproperty
    a_shock: assert property (p_shock) else $error("shock overrun");

    property p_quiet;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == T_QUIET && odr_tick_i && tap_over_i) |=> st_q == T_HOLD;
    endproperty
    a_quiet: assert property (p_quiet) else $error("quiet broken");

    property p_gap;
        @(posedge clk_i) disable iff (rst_i)
        (st_q == T_GAP && odr_tick_i && tcnt_q >= gap_lim) |=> st_q == T_IDLE;
    endproperty
    a_gap: assert property (p_gap) else $error("gap not closed");

    property p_mode;
        @(posedge clk_i) disable iff (rst_i)
        (stap_p_q |-> $past(!dbl)) and (dtap_p_q |-> $past(dbl));
    endproperty
    a_mode: assert property (p_mode) else $error("tap mode mismatch");

    property p_sleep_off;
        @(posedge clk_i) disable iff (rst_i) !sleep_en |=> !evt_q.sleep;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep on");

    property p_sleep_time;
        @(posedge clk_i) disable iff (rst_i)
        $rose(evt_q.sleep) |-> $past(icnt_q) >= $past(sleep_lim);
    endproperty
    a_sleep_time: assert property (p_sleep_time)
        else $error("early sleep");

    property p_overrun;
        @(posedge clk_i) disable iff (rst_i)
        (fifo_full_i && fifo_overwrite_i) |=> evt_q.overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost");

    property p_fall;
        @(posedge clk_i) disable iff (rst_i)
        fall_p |=> evt_q.fall;
    endproperty
    a_fall: assert property (p_fall) else $error("fall flag lost");

endmodule : mecs_regs

/* File: verification/mecs_host.sv */
// Wishbone host model that issues single register accesses.
`timescale 1ns/1ps
module mecs_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One classic cycle; ok stays low when no answer comes in time.
    task automatic xfer(input logic we, input logic [7:0] a,
            input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= a;
        sel_o <= 4'h1;
        dat_o <= {24'h0, wd};
        n = 0;
        ok = 1'b0;
        rd = 8'h00;
        while (!ok && n < 16) begin
            @(posedge clk_i);
            n++;
            if (ack_i === 1'b1) begin
                ok = 1'b1;
                rd = dat_i[7:0];
            end
        end
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= ~a;
        sel_o <= 4'h0;
        dat_o <= ~dat_o;
    endtask : xfer
endmodule : mecs_host

/* File: verification/motion_event_config_status_test.sv */
// Self-checking bench of the motion event register bank.
`timescale 1ns/1ps
module motion_event_config_status_test;
    import mecs_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, pin;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic tick = 1'b0, slow = 1'b0, rdy = 1'b0, over = 1'b0, ori = 1'b0;
    logic full = 1'b0, ovw = 1'b0;
    logic [7:0] fmag = 8'hff;
    mecs_axis_t axes = '0;
    mecs_evt_t evt;
    logic [7:0] fdec [8] = '{8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0d,
        8'h0f, 8'h10};
    int err_count = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        tick <= !rst_i && (!slow || !tick);
    end

    mecs_regs mecs_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .odr_tick_i(tick),
        .data_ready_i(rdy), .tap_over_i(over), .axis_mag_i(axes),
        .fall_mag_i(fmag), .orient_change_i(ori), .fifo_full_i(full),
        .fifo_overwrite_i(ovw), .evt_o(evt), .interrupt_pin_one_o(pin)
    );
    mecs_host mecs_host_i (
        .clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat)
    );

    task automatic test_done();
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [7:0] e,
            input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc_n

    task automatic bus(input logic w, input logic [7:0] a,
            input logic [7:0] wd, output logic [7:0] rd);
        logic ok;
        mecs_host_i.xfer(w, a, wd, rd, ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected ack at %h exp 1 got 0", a);
            test_done();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        chk($sformatf("reg %h", a), e, r);
    endtask : rdc

    // Waits a bounded time for one event flag to rise.
    task automatic wait_evt(input int b, input int lim);
        int n;
        n = 0;
        while (evt[b] !== 1'b1 && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        samples_checked++;
        if (evt[b] !== 1'b1) begin
            err_count++;
            $display("unexpected evt bit %0d exp 1 got %b", b, evt[b]);
            test_done();
        end
    endtask : wait_evt

    // Holds the tap level over for n clock cycles, then releases it.
    task automatic tap(input int n);
        @(posedge clk_i);
        over <= 1'b1;
        repeat (n) @(posedge clk_i);
        over <= 1'b0;
    endtask : tap

    task automatic s_regs();
        for (int i = 0; i < 6; i++) begin
            rdc(8'hc8 + 8'(4 * i), 8'h00);
        end
        rdc(8'h40, 8'h00);
        wr(8'hd8, 8'hff);
        wr(8'hdc, 8'hff);
        rdc(8'hd8, 8'h00);
        rdc(8'hdc, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(8'hc8 + 8'(4 * i), 8'h5a + 8'(i));
            rdc(8'hc8 + 8'(4 * i), 8'h5a + 8'(i));
            wr(8'hc8 + 8'(4 * i), 8'h00);
        end
    endtask : s_regs

    task automatic s_route_status();
        @(posedge clk_i);
        full <= 1'b1;
        cyc_n(3);
        chk("pin", 8'h00, {7'h0, pin});
        wr(8'hd0, 8'h10);
        cyc_n(2);
        chk("pin", 8'h01, {7'h0, pin});
        @(posedge clk_i);
        full <= 1'b0;
        {rdy, ori, ovw} <= 3'b111;
        @(posedge clk_i);
        {rdy, ori, ovw} <= 3'b000;
        cyc_n(2);
        chk("pin", 8'h00, {7'h0, pin});
        chk("evt", 8'h05, evt);
        wr(8'hd0, 8'h00);
        @(posedge clk_i);
        {full, ovw} <= 2'b11;
        @(posedge clk_i);
        {full, ovw} <= 2'b00;
        cyc_n(2);
        chk("pin", 8'h00, {7'h0, pin});
        rdc(8'hd8, 8'h85);
        rdc(8'hd8, 8'h00);
    endtask : s_route_status

    task automatic s_tap();
        wr(8'hc8, 8'h01);
        tap(9);
        cyc_n(4);
        chk("evt", 8'h00, evt);
        tap(8);
        wait_evt(3, 6);
        rdc(8'hd8, 8'h08);
        wr(8'hcc, 8'h80);
        wr(8'hc8, 8'h15);
        tap(2);
        cyc_n(6);
        tap(2);
        wait_evt(4, 6);
        rdc(8'hd8, 8'h10);
        tap(2);
        tap(2);
        cyc_n(6);
        chk("evt", 8'h00, evt);
        cyc_n(60);
        tap(2);
        cyc_n(40);
        tap(2);
        cyc_n(6);
        chk("evt", 8'h00, evt);
        cyc_n(60);
    endtask : s_tap

    task automatic s_wake_sleep();
        wr(8'hcc, 8'h3e);
        wr(8'hd0, 8'h20);
        @(posedge clk_i);
        axes <= '{6'h3e, 6'h3e, 6'h3e};
        cyc_n(4);
        chk("evt", 8'h00, evt);
        axes <= '{6'h3f, 6'h00, 6'h00};
        @(posedge clk_i);
        axes <= '0;
        cyc_n(3);
        chk("evt", 8'h00, evt);
        axes <= '{6'h00, 6'h00, 6'h3f};
        repeat (2) @(posedge clk_i);
        axes <= '0;
        wait_evt(6, 4);
        rdc(8'hdc, 8'h09);
        rdc(8'hdc, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'hd0, 8'h01);
        cyc_n(600);
        chk("evt", 8'h00, evt);
        wr(8'hcc, 8'h40);
        cyc_n(490);
        chk("evt", 8'h00, evt);
        wait_evt(5, 60);
        rdc(8'hdc, 8'h10);
        rdc(8'hdc, 8'h10);
        axes <= '{6'h01, 6'h00, 6'h00};
        @(posedge clk_i);
        axes <= '0;
        cyc_n(2);
        chk("evt", 8'h40, evt);
        wr(8'hcc, 8'h00);
        rdc(8'hd8, 8'h40);
        rdc(8'hdc, 8'h04);
    endtask : s_wake_sleep

    task automatic s_fall();
        for (int c = 0; c < 8; c++) begin
            wr(8'hd4, {5'h01, 3'(c)});
            fmag <= fdec[c];
            cyc_n(4);
            chk("evt", 8'h00, evt);
            fmag <= fdec[c] - 8'h01;
            wait_evt(1, 6);
            fmag <= 8'hff;
            rdc(8'hd8, 8'h02);
        end
        wr(8'hd0, 8'h80);
        wr(8'hd4, 8'h00);
        fmag <= 8'h04;
        cyc_n(25);
        chk("evt", 8'h00, evt);
        wait_evt(1, 20);
        fmag <= 8'hff;
        rdc(8'hd8, 8'h02);
        slow <= 1'b1;
        fmag <= 8'h04;
        cyc_n(50);
        chk("evt", 8'h00, evt);
        wait_evt(1, 30);
        fmag <= 8'hff;
        slow <= 1'b0;
    endtask : s_fall

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs();
        s_route_status();
        s_tap();
        s_wake_sleep();
        s_fall();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        test_done();
    end
endmodule : motion_event_config_status_test
